// ===== logic/dsc_consts.svh
/*
  Constants of the dual-synthesizer control bank: serial word layout,
  word addresses, field positions, reset values, selector codes and pin
  indices. Assumes the including file needs no other definitions.
*/
`ifndef DSC_CONSTS_SVH
`define DSC_CONSTS_SVH

// ----------------------------------------------------------------------
// serial word layout
// ----------------------------------------------------------------------
`define DSC_SHIFT_W 22
`define DSC_DATA_W 20
`define DSC_ADDR_W 2
`define DSC_WORD_CNT 4

// ----------------------------------------------------------------------
// word addresses (low two bits of the serial word)
// ----------------------------------------------------------------------
`define DSC_ADDR_B_REF 2'h0
`define DSC_ADDR_B_FB 2'h1
`define DSC_ADDR_A_REF 2'h2
`define DSC_ADDR_A_FB 2'h3
`define DSC_WORD_RESET 20'h00000

// ----------------------------------------------------------------------
// field positions inside the 20 stored data bits (serial bit minus 2)
// ----------------------------------------------------------------------
`define DSC_REF_COUNT_LSB 0
`define DSC_REF_COUNT_W 15
`define DSC_REF_SENSE_POS 15
`define DSC_REF_GAIN_POS 16
`define DSC_REF_FLOAT_POS 17
`define DSC_REF_SEL_LO_POS 18
`define DSC_REF_SEL_HI_POS 19
`define DSC_FB_SWALLOW_LSB 0
`define DSC_FB_SWALLOW_W 7
`define DSC_FB_BINARY_LSB 7
`define DSC_FB_BINARY_W 11
`define DSC_FB_MODULUS_POS 18
`define DSC_FB_SLEEP_POS 19

// ----------------------------------------------------------------------
// multi-function output selector codes
// ----------------------------------------------------------------------
`define DSC_SEL_W 4
`define DSC_SEL_LOW 4'h0
`define DSC_SEL_B_REF 4'h1
`define DSC_SEL_A_REF 4'h2
`define DSC_SEL_ASSIST 4'h3
`define DSC_SEL_B_LOCK 4'h4
`define DSC_SEL_B_FB 4'h5
`define DSC_SEL_A_FB 4'h6
`define DSC_SEL_B_RESET 4'h7
`define DSC_SEL_A_LOCK 4'h8
`define DSC_SEL_B_REF_ALT 4'h9
`define DSC_SEL_A_REF_ALT 4'ha
`define DSC_SEL_A_RESET 4'hb
`define DSC_SEL_BOTH_LOCK 4'hc
`define DSC_SEL_B_FB_ALT 4'hd
`define DSC_SEL_A_FB_ALT 4'he
`define DSC_SEL_ALL_RESET 4'hf

// ----------------------------------------------------------------------
// indices of the asynchronous pins into the synchroniser bank
// ----------------------------------------------------------------------
`define DSC_PIN_CNT 12
`define DSC_PIN_SER_CLK 0
`define DSC_PIN_SER_DATA 1
`define DSC_PIN_LATCH 2
`define DSC_PIN_A_REF 3
`define DSC_PIN_A_FB 4
`define DSC_PIN_A_LOCK 5
`define DSC_PIN_A_DONE 6
`define DSC_PIN_B_REF 7
`define DSC_PIN_B_FB 8
`define DSC_PIN_B_LOCK 9
`define DSC_PIN_B_DONE 10
`define DSC_PIN_ASSIST 11

`endif

// ===== logic/dsc_pkg.sv
/*
  Types of the dual-synthesizer control bank.
  Assumes dsc_consts.svh is on the include path.
*/
`include "dsc_consts.svh"

package dsc_pkg;

  // per-loop power state
  typedef enum logic [2:0] {
    DSC_AWAKE   = 3'b001,
    DSC_PENDING = 3'b010,
    DSC_ASLEEP  = 3'b100
  } dsc_sleep_state_t;

  // decoded settings of one synthesizer loop
  typedef struct packed {
    logic [`DSC_REF_COUNT_W-1:0] ref_count;
    logic detector_sense;
    logic pump_gain;
    logic pump_float;
    logic [`DSC_FB_SWALLOW_W-1:0] swallow_count;
    logic [`DSC_FB_BINARY_W-1:0] binary_count;
    logic modulus_sel;
    logic sleep;
    logic asleep;
    logic counter_hold;
  } dsc_synth_cfg_t;

  // status signals coming back from one loop's analog side
  typedef struct packed {
    logic ref_div;
    logic fb_div;
    logic lock;
    logic pump_done;
  } dsc_synth_stat_t;

  // state of one pin synchroniser
  typedef struct packed {
    logic meta_r;
    logic level_r;
    logic prev_r;
  } dsc_sync_state_t;

  // state of the control bank
  typedef struct packed {
    logic [`DSC_SHIFT_W-1:0] shift_r;
    logic [`DSC_WORD_CNT-1:0][`DSC_DATA_W-1:0] word_r;
    dsc_sleep_state_t sleep_a_r;
    dsc_sleep_state_t sleep_b_r;
    logic mfo_r;
    logic mfo_oe_r;
  } dsc_bank_state_t;

endpackage

// ===== logic/dsc_pin_sync.sv
/*
  Two-flop synchroniser for one asynchronous pin, with a rising-edge
  pulse taken from the synchronised level.
  Assumes the pin is quasi-static relative to clk_in.
*/
`timescale 1ns/10ps

module dsc_pin_sync (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // pin side
  input wire logic pin_in,
  // synchronised side
  output logic level_out,
  output logic rise_out
);

  dsc_pkg::dsc_sync_state_t st_r;
  dsc_pkg::dsc_sync_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.meta_r = pin_in;
    st_nxt.level_r = st_r.meta_r;
    st_nxt.prev_r = st_r.level_r;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_out = st_r.level_r;
  assign rise_out = st_r.level_r & ~st_r.prev_r;

endmodule

// ===== logic/dsc_control_bank.sv
/*
  Control-register bank of a dual phase-locked-loop synthesizer: a
  three-wire serial port loads four 20-bit write-only words, which are
  decoded into per-loop settings, power states, counter holds and the
  multi-function output pin.
  Assumes the serial pins, divider outputs, lock and pump-done signals
  all arrive from outside the clk_in domain and change slowly against it.

*/
`timescale 1ns/10ps
`include "dsc_consts.svh"

module dsc_control_bank (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // three-wire serial port
  input wire logic ser_clk_in,
  input wire logic ser_data_in,
  input wire logic latch_strobe_in,
  // loop a analog status
  input wire logic synth_a_ref_div_in,
  input wire logic synth_a_fb_div_in,
  input wire logic synth_a_lock_in,
  input wire logic synth_a_pump_done_in,
  // loop b analog status
  input wire logic synth_b_ref_div_in,
  input wire logic synth_b_fb_div_in,
  input wire logic synth_b_lock_in,
  input wire logic synth_b_pump_done_in,
  // fast-lock request from the acquisition logic
  input wire logic lock_assist_in,
  // decoded loop settings
  output dsc_pkg::dsc_synth_cfg_t synth_a_cfg_out,
  output dsc_pkg::dsc_synth_cfg_t synth_b_cfg_out,
  // multi-function output pin
  output logic [`DSC_SEL_W-1:0] multi_output_select_out,
  output logic mfo_out,
  output logic mfo_oe_out
);

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  dsc_pkg::dsc_bank_state_t st_r;
  dsc_pkg::dsc_bank_state_t st_nxt;

  // --------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------
  logic [`DSC_PIN_CNT-1:0] pin_raw;
  logic [`DSC_PIN_CNT-1:0] pin_level;
  logic [`DSC_PIN_CNT-1:0] pin_rise;

  assign pin_raw[`DSC_PIN_SER_CLK] = ser_clk_in;
  assign pin_raw[`DSC_PIN_SER_DATA] = ser_data_in;
  assign pin_raw[`DSC_PIN_LATCH] = latch_strobe_in;

  assign pin_raw[`DSC_PIN_A_REF] = synth_a_ref_div_in;
  assign pin_raw[`DSC_PIN_A_FB] = synth_a_fb_div_in;
  assign pin_raw[`DSC_PIN_A_LOCK] = synth_a_lock_in;
  assign pin_raw[`DSC_PIN_A_DONE] = synth_a_pump_done_in;

  assign pin_raw[`DSC_PIN_B_REF] = synth_b_ref_div_in;
  assign pin_raw[`DSC_PIN_B_FB] = synth_b_fb_div_in;
  assign pin_raw[`DSC_PIN_B_LOCK] = synth_b_lock_in;
  assign pin_raw[`DSC_PIN_B_DONE] = synth_b_pump_done_in;

  assign pin_raw[`DSC_PIN_ASSIST] = lock_assist_in;

  // serial edges under two cycles apart are lost
  genvar gi;
  generate
    for (gi = 0; gi < `DSC_PIN_CNT; gi = gi + 1) begin : g_sync
      dsc_pin_sync u_sync (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .pin_in(pin_raw[gi]),
        .level_out(pin_level[gi]),
        .rise_out(pin_rise[gi])
      );
    end
  endgenerate

  // --------------------------------------------------------------------
  // synchronised status, grouped per loop
  // --------------------------------------------------------------------
  dsc_pkg::dsc_synth_stat_t stat_a;
  dsc_pkg::dsc_synth_stat_t stat_b;
  logic done_a_rise;
  logic done_b_rise;

  assign stat_a.ref_div = pin_level[`DSC_PIN_A_REF];
  assign stat_a.fb_div = pin_level[`DSC_PIN_A_FB];
  assign stat_a.lock = pin_level[`DSC_PIN_A_LOCK];
  assign stat_a.pump_done = pin_level[`DSC_PIN_A_DONE];

  assign stat_b.ref_div = pin_level[`DSC_PIN_B_REF];
  assign stat_b.fb_div = pin_level[`DSC_PIN_B_FB];
  assign stat_b.lock = pin_level[`DSC_PIN_B_LOCK];
  assign stat_b.pump_done = pin_level[`DSC_PIN_B_DONE];

  // end of a pump pulse, as an edge
  assign done_a_rise = pin_rise[`DSC_PIN_A_DONE];
  assign done_b_rise = pin_rise[`DSC_PIN_B_DONE];

  // --------------------------------------------------------------------
  // stored words
  // --------------------------------------------------------------------
  logic [`DSC_DATA_W-1:0] a_ref_word;
  logic [`DSC_DATA_W-1:0] a_fb_word;
  logic [`DSC_DATA_W-1:0] b_ref_word;
  logic [`DSC_DATA_W-1:0] b_fb_word;

  // the decoders, the selector and the power-state step read the words
  assign a_ref_word = st_r.word_r[`DSC_ADDR_A_REF];
  assign a_fb_word = st_r.word_r[`DSC_ADDR_A_FB];
  assign b_ref_word = st_r.word_r[`DSC_ADDR_B_REF];
  assign b_fb_word = st_r.word_r[`DSC_ADDR_B_FB];

  // --------------------------------------------------------------------
  // multi-function selector
  // --------------------------------------------------------------------
  logic [`DSC_SEL_W-1:0] sel;

  assign sel = {a_ref_word[`DSC_REF_SEL_LO_POS],
                b_ref_word[`DSC_REF_SEL_LO_POS],
                a_ref_word[`DSC_REF_SEL_HI_POS],
                b_ref_word[`DSC_REF_SEL_HI_POS]};

  logic hold_sel_a;
  logic hold_sel_b;

  assign hold_sel_a = (sel == `DSC_SEL_A_RESET)
    || (sel == `DSC_SEL_ALL_RESET);
  assign hold_sel_b = (sel == `DSC_SEL_B_RESET)
    || (sel == `DSC_SEL_ALL_RESET);

  // --------------------------------------------------------------------
  // power state step for one loop
  // --------------------------------------------------------------------
  function automatic dsc_pkg::dsc_sleep_state_t next_sleep(
    input dsc_pkg::dsc_sleep_state_t cur,
    input logic sleep,
    input logic float_pump,
    input logic done_rise
  );
    dsc_pkg::dsc_sleep_state_t nxt;
    nxt = cur;

    // float with sleep skips the pump wait
    unique case (cur)
      dsc_pkg::DSC_AWAKE: begin
        if (sleep && float_pump) begin
          nxt = dsc_pkg::DSC_ASLEEP;
        end else if (sleep) begin
          nxt = dsc_pkg::DSC_PENDING;
        end
      end
      dsc_pkg::DSC_PENDING: begin
        if (!sleep) begin
          nxt = dsc_pkg::DSC_AWAKE;
        end else if (float_pump || done_rise) begin
          // leaves at the end of the next pump pulse, or at once on float
          nxt = dsc_pkg::DSC_ASLEEP;
        end
      end
      dsc_pkg::DSC_ASLEEP: begin
        if (!sleep) begin
          nxt = dsc_pkg::DSC_AWAKE;
        end
      end
      default: begin
        nxt = dsc_pkg::DSC_AWAKE;
      end
    endcase
    return nxt;
  endfunction

  // --------------------------------------------------------------------
  // decode one loop's words into its settings
  // --------------------------------------------------------------------
  function automatic dsc_pkg::dsc_synth_cfg_t decode_cfg(
    input logic [`DSC_DATA_W-1:0] ref_word,
    input logic [`DSC_DATA_W-1:0] fb_word,
    input dsc_pkg::dsc_sleep_state_t pwr,
    input logic hold_sel
  );
    dsc_pkg::dsc_synth_cfg_t cfg;
    cfg = '0;
    cfg.ref_count = ref_word[`DSC_REF_COUNT_LSB +: `DSC_REF_COUNT_W];
    cfg.detector_sense = ref_word[`DSC_REF_SENSE_POS];
    cfg.pump_gain = ref_word[`DSC_REF_GAIN_POS];
    // straight from the stored bit, no extra clocking
    cfg.pump_float = ref_word[`DSC_REF_FLOAT_POS];

    cfg.swallow_count = fb_word[`DSC_FB_SWALLOW_LSB +: `DSC_FB_SWALLOW_W];
    cfg.binary_count = fb_word[`DSC_FB_BINARY_LSB +: `DSC_FB_BINARY_W];
    cfg.modulus_sel = fb_word[`DSC_FB_MODULUS_POS];
    cfg.sleep = fb_word[`DSC_FB_SLEEP_POS];

    cfg.asleep = (pwr == dsc_pkg::DSC_ASLEEP);
    // dividers sit at their load point while reset is selected or asleep
    cfg.counter_hold = hold_sel || (pwr == dsc_pkg::DSC_ASLEEP);
    return cfg;
  endfunction

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  logic shift_edge;
  logic latch_edge;
  logic [`DSC_ADDR_W-1:0] load_addr;
  logic [`DSC_DATA_W-1:0] load_data;

  assign shift_edge = pin_rise[`DSC_PIN_SER_CLK];
  assign latch_edge = pin_rise[`DSC_PIN_LATCH];
  assign load_addr = st_r.shift_r[`DSC_ADDR_W-1:0];
  assign load_data = st_r.shift_r[`DSC_SHIFT_W-1:`DSC_ADDR_W];

  always_comb begin
    st_nxt = st_r;

    // serial shift, first bit ends up in the top position
    if (shift_edge) begin
      st_nxt.shift_r = {st_r.shift_r[`DSC_SHIFT_W-2:0],
                        pin_level[`DSC_PIN_SER_DATA]};
    end

    // words change only on a latch and are never read back
    // a latch in mid-word stores a half-shifted word
    if (latch_edge) begin
      st_nxt.word_r[load_addr] = load_data;
    end

    // power state of each loop
    st_nxt.sleep_a_r = next_sleep(st_r.sleep_a_r,
                                  a_fb_word[`DSC_FB_SLEEP_POS],
                                  a_ref_word[`DSC_REF_FLOAT_POS],
                                  done_a_rise);
    st_nxt.sleep_b_r = next_sleep(st_r.sleep_b_r,
                                  b_fb_word[`DSC_FB_SLEEP_POS],
                                  b_ref_word[`DSC_REF_FLOAT_POS],
                                  done_b_rise);

    // multi-function output pin
    st_nxt.mfo_oe_r = 1'b1;
    st_nxt.mfo_r = 1'b0;
    // pin lags its status input by three cycles
    unique case (sel)
      `DSC_SEL_LOW: begin
        st_nxt.mfo_r = 1'b0;
      end
      `DSC_SEL_B_REF, `DSC_SEL_B_REF_ALT: begin
        st_nxt.mfo_r = stat_b.ref_div;
      end
      `DSC_SEL_A_REF, `DSC_SEL_A_REF_ALT: begin
        st_nxt.mfo_r = stat_a.ref_div;
      end
      `DSC_SEL_B_FB, `DSC_SEL_B_FB_ALT: begin
        st_nxt.mfo_r = stat_b.fb_div;
      end
      `DSC_SEL_A_FB, `DSC_SEL_A_FB_ALT: begin
        st_nxt.mfo_r = stat_a.fb_div;
      end
      `DSC_SEL_B_LOCK: begin
        st_nxt.mfo_r = stat_b.lock;
      end
      `DSC_SEL_A_LOCK: begin
        st_nxt.mfo_r = stat_a.lock;
      end
      `DSC_SEL_BOTH_LOCK: begin
        st_nxt.mfo_r = stat_a.lock & stat_b.lock;
      end
      `DSC_SEL_ASSIST: begin
        // open drain: pull low only while fast lock is requested
        st_nxt.mfo_r = 1'b0;
        st_nxt.mfo_oe_r = pin_level[`DSC_PIN_ASSIST];
      end
      `DSC_SEL_B_RESET, `DSC_SEL_A_RESET, `DSC_SEL_ALL_RESET: begin
        st_nxt.mfo_r = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  // zero words: loops awake and unheld
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_r.shift_r <= '0;
      st_r.word_r <= {`DSC_WORD_CNT{`DSC_WORD_RESET}};
      st_r.sleep_a_r <= dsc_pkg::DSC_AWAKE;
      st_r.sleep_b_r <= dsc_pkg::DSC_AWAKE;
      st_r.mfo_r <= 1'b0;
      st_r.mfo_oe_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign synth_a_cfg_out = decode_cfg(
    a_ref_word,
    a_fb_word,
    st_r.sleep_a_r,
    hold_sel_a
  );
  assign synth_b_cfg_out = decode_cfg(
    b_ref_word,
    b_fb_word,
    st_r.sleep_b_r,
    hold_sel_b
  );
  assign multi_output_select_out = sel;
  assign mfo_out = st_r.mfo_r;
  assign mfo_oe_out = st_r.mfo_oe_r;

endmodule

// ===== test/dsc_host_model.sv
/*
  Host model: shifts words into the three-wire port.
  Assumes clk_in runs at 10 MHz and the caller waits for the task to return.
*/
`timescale 1ns/10ps
`include "dsc_consts.svh"

module dsc_host_model (
  // clock
  input wire logic clk_in,
  // serial port
  output logic ser_clk_out,
  output logic ser_data_out,
  output logic latch_strobe_out
);
  initial begin
    ser_clk_out = 1'b0;
    ser_data_out = 1'b0;
    latch_strobe_out = 1'b0;
  end

  // msb first, address last, then latch; half is cycles per clock phase
  task automatic send(input logic [`DSC_SHIFT_W-1:0] w, input int half);
    int i;
    @(posedge clk_in);
    for (i = `DSC_SHIFT_W - 1; i >= 0; i--) begin
      ser_clk_out <= 1'b0;
      ser_data_out <= w[i];
      repeat (half) @(posedge clk_in);
      ser_clk_out <= 1'b1;
      repeat (half) @(posedge clk_in);
    end
    ser_clk_out <= 1'b0;
    // released data line shows the inverse of the last bit
    ser_data_out <= ~w[0];
    repeat (half) @(posedge clk_in);
    latch_strobe_out <= 1'b1;
    repeat (half) @(posedge clk_in);
    latch_strobe_out <= 1'b0;
    repeat (6) @(posedge clk_in);
  endtask
endmodule

// ===== test/dsc_control_bank_sva.sv
/*
  Checker of the control bank, bound to its ports.
  Assumes status pins are held for several cycles around each change.
*/
`timescale 1ns/10ps
`include "dsc_consts.svh"

module dsc_control_bank_sva (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // watched inputs
  input wire logic latch_strobe_in,
  input wire logic synth_a_ref_div_in,
  input wire logic synth_a_fb_div_in,
  input wire logic synth_a_lock_in,
  input wire logic synth_a_pump_done_in,
  input wire logic synth_b_ref_div_in,
  input wire logic synth_b_fb_div_in,
  input wire logic synth_b_lock_in,
  input wire logic lock_assist_in,
  // watched outputs
  input dsc_pkg::dsc_synth_cfg_t synth_a_cfg_out,
  input dsc_pkg::dsc_synth_cfg_t synth_b_cfg_out,
  input wire logic [`DSC_SEL_W-1:0] multi_output_select_out,
  input wire logic mfo_out,
  input wire logic mfo_oe_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  // ----------------------------------------------------------------------
  // helper: status delayed to match the pin lag, latch history
  // ----------------------------------------------------------------------
  logic [6:0] s1, s2, lh;
  logic pp, ex;
  always_ff @(posedge clk_in) begin
    s1 <= {lock_assist_in, synth_b_lock_in, synth_a_lock_in, synth_b_fb_div_in,
           synth_a_fb_div_in, synth_b_ref_div_in, synth_a_ref_div_in};
    s2 <= s1;
    lh <= {lh[5:0], latch_strobe_in};
  end
  always_comb begin
    pp = 1'b1;
    case (multi_output_select_out)
      `DSC_SEL_A_REF, `DSC_SEL_A_REF_ALT: ex = s2[0];
      `DSC_SEL_B_REF, `DSC_SEL_B_REF_ALT: ex = s2[1];
      `DSC_SEL_A_FB, `DSC_SEL_A_FB_ALT: ex = s2[2];
      `DSC_SEL_B_FB, `DSC_SEL_B_FB_ALT: ex = s2[3];
      `DSC_SEL_A_LOCK: ex = s2[4];
      `DSC_SEL_B_LOCK: ex = s2[5];
      `DSC_SEL_BOTH_LOCK: ex = s2[4] & s2[5];
      default: begin
        pp = 1'b0;
        ex = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  property p_push;
    pp |=> mfo_out == $past(ex) && mfo_oe_out;
  endproperty
  a_push: assert property (p_push) else $error("push-pull source wrong");

  property p_low;
    multi_output_select_out inside {`DSC_SEL_LOW, `DSC_SEL_B_RESET, `DSC_SEL_A_RESET,
      `DSC_SEL_ALL_RESET} |=> !mfo_out && mfo_oe_out;
  endproperty
  a_low: assert property (p_low) else $error("pin not driven low");

  property p_fast;
    multi_output_select_out == `DSC_SEL_ASSIST |=> !mfo_out && mfo_oe_out == $past(s2[6]);
  endproperty
  a_fast: assert property (p_fast) else $error("open-drain switch wrong");

  property p_hold_a;
    multi_output_select_out inside {`DSC_SEL_A_RESET, `DSC_SEL_ALL_RESET}
      |-> synth_a_cfg_out.counter_hold;
  endproperty
  a_hold_a: assert property (p_hold_a) else $error("loop a not held");

  property p_hold_b;
    multi_output_select_out inside {`DSC_SEL_B_RESET, `DSC_SEL_ALL_RESET}
      |-> synth_b_cfg_out.counter_hold;
  endproperty
  a_hold_b: assert property (p_hold_b) else $error("loop b not held");

  property p_keep;
    (lh == 7'h00 || lh == 7'h7f) |-> $stable(multi_output_select_out)
      && $stable(synth_a_cfg_out.ref_count) && $stable(synth_b_cfg_out.binary_count);
  endproperty
  a_keep: assert property (p_keep) else $error("word changed without latch");

  property p_sleep_now;
    synth_a_cfg_out.sleep && synth_a_cfg_out.pump_float |=> synth_a_cfg_out.asleep;
  endproperty
  a_sleep_now: assert property (p_sleep_now) else $error("no immediate sleep");

  property p_awake;
    !synth_b_cfg_out.sleep |=> !synth_b_cfg_out.asleep;
  endproperty
  a_awake: assert property (p_awake) else $error("loop b asleep while active");

  property p_sleep_sync;
    $rose(synth_a_cfg_out.asleep) && !synth_a_cfg_out.pump_float
      |-> $past(synth_a_pump_done_in, 3);
  endproperty
  a_sleep_sync: assert property (p_sleep_sync) else $error("sleep before pump end");
endmodule

bind dsc_control_bank dsc_control_bank_sva i_dsc_control_bank_sva (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .latch_strobe_in(latch_strobe_in),
  .synth_a_ref_div_in(synth_a_ref_div_in), .synth_a_fb_div_in(synth_a_fb_div_in),
  .synth_a_lock_in(synth_a_lock_in), .synth_a_pump_done_in(synth_a_pump_done_in),
  .synth_b_ref_div_in(synth_b_ref_div_in), .synth_b_fb_div_in(synth_b_fb_div_in),
  .synth_b_lock_in(synth_b_lock_in), .lock_assist_in(lock_assist_in),
  .synth_a_cfg_out(synth_a_cfg_out), .synth_b_cfg_out(synth_b_cfg_out),
  .multi_output_select_out(multi_output_select_out), .mfo_out(mfo_out),
  .mfo_oe_out(mfo_oe_out)
);

// ===== test/dsc_control_bank_tb.sv
/*
  Testbench of the control bank: fields, selector codes, power modes.
  Assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/10ps
`include "dsc_consts.svh"

module dsc_control_bank_tb;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [8:0] st = 9'h000;
  logic ser_clk, ser_data, latch, mfo, mfo_oe;
  logic [`DSC_SEL_W-1:0] sel;
  dsc_pkg::dsc_synth_cfg_t cfg_a, cfg_b;
  int checks = 0;
  int num_errors = 0;

  always #50 clk_in = ~clk_in;

  dsc_host_model i_dsc_host_model (.clk_in(clk_in), .ser_clk_out(ser_clk),
    .ser_data_out(ser_data), .latch_strobe_out(latch));

  dsc_control_bank i_dsc_control_bank (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .ser_clk_in(ser_clk), .ser_data_in(ser_data), .latch_strobe_in(latch),
    .synth_a_ref_div_in(st[0]), .synth_a_fb_div_in(st[1]), .synth_a_lock_in(st[2]),
    .synth_a_pump_done_in(st[3]), .synth_b_ref_div_in(st[4]), .synth_b_fb_div_in(st[5]),
    .synth_b_lock_in(st[6]), .synth_b_pump_done_in(st[7]), .lock_assist_in(st[8]),
    .synth_a_cfg_out(cfg_a), .synth_b_cfg_out(cfg_b), .multi_output_select_out(sel),
    .mfo_out(mfo), .mfo_oe_out(mfo_oe));

  // ----------------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [1:0] adr, input logic [19:0] d, input int half);
    i_dsc_host_model.send({d, adr}, half);
    @(negedge clk_in);
  endtask

  function automatic logic [19:0] mkref(input logic [14:0] c, input logic sn, gn, fl, hi, lo);
    mkref = {hi, lo, fl, gn, sn, c};
  endfunction

  function automatic logic [19:0] mkfb(input logic [6:0] sw, input logic [10:0] bn,
                                       input logic md, sl);
    mkfb = {sl, md, bn, sw};
  endfunction

  function automatic logic [1:0] mfo_exp(input logic [3:0] k, input logic [8:0] s);
    case (k)
      `DSC_SEL_B_REF, `DSC_SEL_B_REF_ALT: mfo_exp = {s[4], 1'b1};
      `DSC_SEL_A_REF, `DSC_SEL_A_REF_ALT: mfo_exp = {s[0], 1'b1};
      `DSC_SEL_B_FB, `DSC_SEL_B_FB_ALT: mfo_exp = {s[5], 1'b1};
      `DSC_SEL_A_FB, `DSC_SEL_A_FB_ALT: mfo_exp = {s[1], 1'b1};
      `DSC_SEL_B_LOCK: mfo_exp = {s[6], 1'b1};
      `DSC_SEL_A_LOCK: mfo_exp = {s[2], 1'b1};
      `DSC_SEL_BOTH_LOCK: mfo_exp = {s[2] & s[6], 1'b1};
      `DSC_SEL_ASSIST: mfo_exp = {1'b0, s[8]};
      default: mfo_exp = 2'b01;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    chk(cfg_a, 48'h0);
    chk(cfg_b, 48'h0);
    chk({sel, mfo, mfo_oe}, 6'h01);
  endtask

  // boundary counts, both field polarities, all four addresses
  task automatic t_fields();
    int i;
    logic b;
    logic [14:0] ca, cb;
    logic [6:0] sa, sb;
    logic [10:0] na, nb;
    for (i = 0; i < 2; i++) begin
      b = i[0];
      ca = b ? 15'h7fff : 15'h0003;
      cb = b ? 15'h0003 : 15'h7fff;
      sa = b ? 7'h00 : 7'h7f;
      na = b ? 11'h003 : 11'h7ff;
      sb = b ? 7'h7f : 7'h00;
      nb = b ? 11'h7ff : 11'h003;
      wr(`DSC_ADDR_A_REF, mkref(ca, b, ~b, 1'b0, 1'b0, 1'b0), 4);
      wr(`DSC_ADDR_B_REF, mkref(cb, ~b, b, 1'b0, 1'b0, 1'b0), 4);
      wr(`DSC_ADDR_A_FB, mkfb(sa, na, ~b, 1'b0), 4);
      wr(`DSC_ADDR_B_FB, mkfb(sb, nb, b, 1'b0), 4);
      chk(cfg_a, {ca, b, ~b, 1'b0, sa, na, ~b, 3'h0});
      chk(cfg_b, {cb, ~b, b, 1'b0, sb, nb, b, 3'h0});
    end
  endtask

  // every selector code with three status patterns
  task automatic t_sel();
    int c, j;
    logic [3:0] k;
    logic [8:0] p;
    for (c = 0; c < 16; c++) begin
      k = c[3:0];
      wr(`DSC_ADDR_A_REF, mkref(15'h0003, 1'b0, 1'b0, 1'b0, k[1], k[3]), 4);
      wr(`DSC_ADDR_B_REF, mkref(15'h0003, 1'b0, 1'b0, 1'b0, k[0], k[2]), 4);
      chk(sel, k);
      chk({cfg_a.counter_hold, cfg_b.counter_hold}, {k == `DSC_SEL_A_RESET ||
          k == `DSC_SEL_ALL_RESET, k == `DSC_SEL_B_RESET || k == `DSC_SEL_ALL_RESET});
      for (j = 0; j < 3; j++) begin
        p = j == 2 ? 9'h042 : j ? 9'h016 : 9'h165;
        @(posedge clk_in);
        st <= p;
        repeat (5) @(posedge clk_in);
        @(negedge clk_in);
        chk({mfo, mfo_oe}, mfo_exp(k, p));
      end
    end
  endtask

  // synchronous then immediate powerdown of loop a
  task automatic t_power();
    wr(`DSC_ADDR_A_REF, mkref(15'h0003, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0), 4);
    wr(`DSC_ADDR_A_FB, mkfb(7'h00, 11'h003, 1'b0, 1'b1), 4);
    repeat (10) @(negedge clk_in);
    chk({cfg_a.sleep, cfg_a.asleep, cfg_a.counter_hold}, 3'h4);
    @(posedge clk_in);
    st[3] <= 1'b1;
    repeat (8) @(posedge clk_in);
    st[3] <= 1'b0;
    @(negedge clk_in);
    chk({cfg_a.sleep, cfg_a.asleep, cfg_a.counter_hold}, 3'h7);
    wr(`DSC_ADDR_A_FB, mkfb(7'h00, 11'h003, 1'b0, 1'b0), 4);
    chk({cfg_a.sleep, cfg_a.asleep, cfg_a.counter_hold}, 3'h0);
    wr(`DSC_ADDR_A_REF, mkref(15'h0003, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0), 4);
    chk({cfg_a.pump_float, cfg_a.asleep}, 2'h2);
    wr(`DSC_ADDR_A_FB, mkfb(7'h00, 11'h003, 1'b0, 1'b1), 4);
    chk({cfg_a.sleep, cfg_a.asleep, cfg_a.counter_hold}, 3'h7);
    wr(`DSC_ADDR_A_FB, mkfb(7'h00, 11'h003, 1'b0, 1'b0), 4);
    wr(`DSC_ADDR_B_FB, mkfb(7'h00, 11'h003, 1'b0, 1'b1), 4);
    chk({cfg_b.sleep, cfg_b.asleep, cfg_b.counter_hold}, 3'h4);
    @(posedge clk_in);
    st[7] <= 1'b1;
    repeat (6) @(negedge clk_in);
    chk({cfg_b.sleep, cfg_b.asleep, cfg_b.counter_hold}, 3'h7);
  endtask

  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    t_reset();
    t_fields();
    t_reset();
    t_sel();
    t_power();
    test_done();
  end

  initial begin
    repeat (40000) @(posedge clk_in);
    num_errors++;
    test_done();
  end
endmodule
